/* File: core/button_deglitch.sv */
// one button input: three-flop synchroniser and falling-edge deglitch
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_regs.svh"

module button_deglitch #(
  parameter int DEGLITCH_TICKS = `DEGLITCH_TICKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // oscillator tick
  input wire logic tick,
  // raw pin and cleaned level
  input wire logic pin_n,
  output logic clean_n
);
  logic s1_q, s2_q, s3_q;
  logic clean_q, clean_d;
  logic [7:0] cnt_q, cnt_d;

  // ----------------------------------------------------------------------
  // deglitch
  // ----------------------------------------------------------------------
  // a low must stay low for the whole period; a release is taken at once
  always_comb begin
    clean_d = clean_q;
    cnt_d = cnt_q;
    if (s2_q != s3_q) begin
      cnt_d = cnt_q;
    end else if (s3_q) begin
      clean_d = 1'b1;
      cnt_d = 8'h00;
    end else if (clean_q && tick) begin
      if (cnt_q == 8'(DEGLITCH_TICKS - 1)) begin
        clean_d = 1'b0; // R8
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      clean_q <= 1'b1;
      cnt_q <= 8'h00;
    end else begin
      s1_q <= pin_n;
      s2_q <= s1_q;
      s3_q <= s2_q;
      clean_q <= clean_d;
      cnt_q <= cnt_d;
    end
  end

  assign clean_n = clean_q;

  chk_deglitch_fall: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(clean_q) |-> $past(cnt_q) == 8'(DEGLITCH_TICKS - 1) && !$past(s3_q)) // R8
    else $error("button low recognised before deglitch period");
endmodule // button_deglitch

`default_nettype wire

/* File: core/pushbutton_reset_supervisor.sv */
// pushbutton reset supervisor: undervoltage and manual reset sequencing
// ----------------------------------------------------------------------
// Overview of operation
// R1 - undervoltage holds reset low, then a full hold period before release
// R2 - manual condition held past setup delay fires one reset pulse of hold length
// R3 - single-button build: soft reset output follows the debounced button
// R4 - dual-button build: condition met only while both buttons are low
// R5 - setup delay picked from select low, floating or high
// R6 - resistor build: setup delay comes from select resistor instead
// R7 - resistor build: setup seconds equal kilohms divided by twenty
// R8 - each button deglitched; falling edge recognised after twenty milliseconds
// R9 - build option skips the hold period at power-up
// R10 - after a pulse, a button must be released before another pulse
// R11 - setup delay tables 0.5/1/2, 3/4/5, 6/8/10, 13/15/17 seconds
// R12 - one factory hold period, from 0.9 ms up to 345.6 ms
// R13 - all periods timed by ticks of one free-running oscillator
// R14 - setup counter restarts when the condition drops early
// ----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_regs.svh"

module pushbutton_reset_supervisor #(
  parameter bit DUAL_BUTTON = 1'b0,
  parameter bit RESISTOR_MODE = 1'b0,
  parameter int DELAY_GROUP = 0,
  parameter int HOLD_INDEX = 0,
  parameter bit SKIP_STARTUP_HOLD = 1'b0,
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int DEGLITCH_TICKS = `DEGLITCH_TICKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // supply comparator
  input wire logic undervoltage,
  // buttons
  input wire logic manual_reset_in_n,
  input wire logic button_a_n,
  input wire logic button_b_n,
  // setup delay select front end
  input wire logic [1:0] sel_level,
  input wire logic [9:0] sel_resistor_kohm,
  // outputs
  output logic reset_out_n,
  output logic soft_reset_out_n
);
  // ----------------------------------------------------------------------
  // terminal counts
  // ----------------------------------------------------------------------
  function automatic supervisor_pkg::hold_cnt_t hold_ticks(input int idx);
    int us;
    case (idx)
      1: us = `HOLD_1_US;
      2: us = `HOLD_2_US;
      3: us = `HOLD_3_US;
      4: us = `HOLD_4_US;
      5: us = `HOLD_5_US;
      6: us = `HOLD_6_US;
      7: us = `HOLD_7_US;
      8: us = `HOLD_8_US;
      9: us = `HOLD_9_US;
      10: us = `HOLD_10_US;
      11: us = `HOLD_11_US;
      12: us = `HOLD_12_US;
      default: us = `HOLD_0_US;
    endcase
    return 12'(`US_TO_TICKS(us)); // R12
  endfunction

  localparam supervisor_pkg::hold_cnt_t HOLD_TERM = hold_ticks(HOLD_INDEX);

  function automatic supervisor_pkg::setup_cnt_t setup_ticks(
      input logic [1:0] lvl, input logic [9:0] kohm);
    int ms;
    ms = `SU_G0_FLT_MS;
    if (RESISTOR_MODE) begin
      ms = int'(kohm) * `SU_MS_PER_KOHM; // R6 R7
    end else begin
      case ({DELAY_GROUP[1:0], lvl}) // R5 R11
        4'h0: ms = `SU_G0_LOW_MS;
        4'h1: ms = `SU_G0_FLT_MS;
        4'h2: ms = `SU_G0_HIGH_MS;
        4'h4: ms = `SU_G1_LOW_MS;
        4'h5: ms = `SU_G1_FLT_MS;
        4'h6: ms = `SU_G1_HIGH_MS;
        4'h8: ms = `SU_G2_LOW_MS;
        4'h9: ms = `SU_G2_FLT_MS;
        4'ha: ms = `SU_G2_HIGH_MS;
        4'hc: ms = `SU_G3_LOW_MS;
        4'hd: ms = `SU_G3_FLT_MS;
        4'he: ms = `SU_G3_HIGH_MS;
        default: ms = `SU_G0_FLT_MS;
      endcase
    end
    return 20'(`MS_TO_TICKS(ms));
  endfunction

  // ----------------------------------------------------------------------
  // oscillator tick
  // ----------------------------------------------------------------------
  logic [11:0] div_q, div_d;
  logic tick_q, tick_d;

  always_comb begin
    tick_d = 1'b0;
    div_d = div_q + 12'h001;
    if (div_q == 12'(TICK_CYCLES - 1)) begin
      div_d = 12'h000;
      tick_d = 1'b1; // R13
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_q <= 12'h000;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  // power-up counts as undervoltage until the comparator is seen
  logic uv1_q, uv2_q, uv3_q, uv_q, uv_d;
  logic [1:0] sl1_q, sl2_q, sl3_q, sel_q, sel_d;
  logic [9:0] kohm_q;

  always_comb begin
    uv_d = (uv2_q == uv3_q) ? uv3_q : uv_q;
    sel_d = (sl2_q == sl3_q) ? sl3_q : sel_q;
  end

  // the resistor value is treated as static once powered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      uv1_q <= 1'b1;
      uv2_q <= 1'b1;
      uv3_q <= 1'b1;
      uv_q <= 1'b1;
      sl1_q <= 2'h1;
      sl2_q <= 2'h1;
      sl3_q <= 2'h1;
      sel_q <= 2'h1;
      kohm_q <= 10'h000;
    end else begin
      uv1_q <= undervoltage;
      uv2_q <= uv1_q;
      uv3_q <= uv2_q;
      uv_q <= uv_d;
      sl1_q <= sel_level;
      sl2_q <= sl1_q;
      sl3_q <= sl2_q;
      sel_q <= sel_d;
      kohm_q <= sel_resistor_kohm;
    end
  end

  // ----------------------------------------------------------------------
  // buttons
  // ----------------------------------------------------------------------
  logic a_clean_n, b_clean_n, cond;

  button_deglitch #(.DEGLITCH_TICKS(DEGLITCH_TICKS)) u_deglitch_a (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick_q),
    .pin_n(DUAL_BUTTON ? button_a_n : manual_reset_in_n),
    .clean_n(a_clean_n)
  );

  button_deglitch #(.DEGLITCH_TICKS(DEGLITCH_TICKS)) u_deglitch_b (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick_q),
    .pin_n(DUAL_BUTTON ? button_b_n : 1'b1),
    .clean_n(b_clean_n)
  );

  assign cond = DUAL_BUTTON ? (!a_clean_n && !b_clean_n) : !a_clean_n; // R4

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  supervisor_pkg::sup_state_e state_q, state_d;
  supervisor_pkg::hold_cnt_t hold_q, hold_d;
  supervisor_pkg::setup_cnt_t setup_q, setup_d;
  logic startup_q, startup_d;
  logic rst_out_q, rst_out_d;
  logic soft_q, soft_d;
  logic armed_q, armed_d;
  logic fire;

  // a count paused by undervoltage may sit at its end; it must not fire from hold
  assign fire = armed_q && cond && tick_q && state_q == supervisor_pkg::ST_RUN &&
                setup_q == setup_ticks(sel_q, kohm_q) - 20'h00001;

  always_comb begin
    state_d = state_q;
    hold_d = hold_q;
    setup_d = setup_q;
    startup_d = startup_q;
    armed_d = armed_q;
    // R10: a release re-arms; without it the count stays at zero
    if (!cond) begin
      armed_d = 1'b1; // R10
    end
    if (!cond || !armed_q) begin
      setup_d = 20'h00000; // R14
    end else if (tick_q && state_q == supervisor_pkg::ST_RUN) begin
      setup_d = fire ? 20'h00000 : setup_q + 20'h00001;
    end
    case (state_q)
      supervisor_pkg::ST_UNDERVOLT: begin
        hold_d = 12'h000;
        if (!uv_q) begin
          if (startup_q && SKIP_STARTUP_HOLD) begin
            state_d = supervisor_pkg::ST_RUN; // R9
          end else begin
            state_d = supervisor_pkg::ST_HOLD;
          end
          startup_d = 1'b0;
        end
      end
      supervisor_pkg::ST_HOLD: begin
        if (tick_q) begin
          if (hold_q == HOLD_TERM - 12'h001) begin
            state_d = supervisor_pkg::ST_RUN; // R1
          end else begin
            hold_d = hold_q + 12'h001;
          end
        end
      end
      supervisor_pkg::ST_RUN: begin
        if (fire) begin
          state_d = supervisor_pkg::ST_HOLD; // R2
          hold_d = 12'h000;
          armed_d = 1'b0;
        end
      end
      default: state_d = supervisor_pkg::ST_UNDERVOLT;
    endcase
    if (uv_q) begin
      state_d = supervisor_pkg::ST_UNDERVOLT; // R1
      hold_d = 12'h000;
    end
    rst_out_d = (state_d == supervisor_pkg::ST_RUN);
    soft_d = DUAL_BUTTON ? 1'b1 : a_clean_n; // R3
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= supervisor_pkg::ST_UNDERVOLT;
      hold_q <= 12'h000;
      setup_q <= 20'h00000;
      startup_q <= 1'b1;
      rst_out_q <= 1'b0;
      soft_q <= 1'b1;
      armed_q <= 1'b1;
    end else begin
      state_q <= state_d;
      hold_q <= hold_d;
      setup_q <= setup_d;
      startup_q <= startup_d;
      rst_out_q <= rst_out_d;
      soft_q <= soft_d;
      armed_q <= armed_d;
    end
  end

  assign reset_out_n = rst_out_q;
  assign soft_reset_out_n = soft_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_uv_holds_low: assert property (@(posedge clk) disable iff (!rst_n) // R1
    uv_q |=> !rst_out_q)
    else $error("reset released during undervoltage");
  chk_hold_keeps_low: assert property (@(posedge clk) disable iff (!rst_n) // R12
    state_q == supervisor_pkg::ST_HOLD && hold_q != HOLD_TERM - 12'h001 |=> !rst_out_q)
    else $error("reset released before hold period ended");
  chk_fire_pulses: assert property (@(posedge clk) disable iff (!rst_n) // R2
    fire && !uv_q |=> !rst_out_q && state_q == supervisor_pkg::ST_HOLD && !armed_q)
    else $error("setup completion did not start a reset pulse");
  chk_soft_mirror: assert property (@(posedge clk) disable iff (!rst_n) // R3
    !DUAL_BUTTON |=> soft_q == $past(a_clean_n))
    else $error("soft reset does not follow the button");
  chk_dual_both: assert property (@(posedge clk) disable iff (!rst_n) // R4
    setup_q != 20'h00000 |-> $past(cond) && (!DUAL_BUTTON || $past(!b_clean_n)))
    else $error("setup counted without both buttons low");
  chk_setup_restart: assert property (@(posedge clk) disable iff (!rst_n) // R14
    !cond |=> setup_q == 20'h00000)
    else $error("setup count kept after condition dropped");
  chk_no_rearm: assert property (@(posedge clk) disable iff (!rst_n) // R10
    !armed_q && cond |=> setup_q == 20'h00000 && !armed_q)
    else $error("second pulse armed without release");
  chk_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n) // R13
    tick_q |=> !tick_q)
    else $error("oscillator tick wider than one cycle");
endmodule // pushbutton_reset_supervisor

`default_nettype wire

/* File: pkg/supervisor_pkg.sv */
// types shared by the pushbutton reset supervisor
package supervisor_pkg;
  // three-level delay select as reported by the pin front end
  typedef enum logic [1:0] {
    SEL_LOW   = 2'h0,
    SEL_FLOAT = 2'h1,
    SEL_HIGH  = 2'h2
  } sel_level_e;

  typedef enum logic [3:0] {
    ST_UNDERVOLT = 4'h1,
    ST_HOLD      = 4'h2,
    ST_RUN       = 4'h4,
    ST_WAIT_REL  = 4'h8
  } sup_state_e;

  typedef logic [19:0] setup_cnt_t;
  typedef logic [11:0] hold_cnt_t;
endpackage

/* File: pkg/supervisor_regs.svh */
// timing constants and selection codes for the pushbutton reset supervisor
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH

// ----------------------------------------------------------------------
// oscillator tick
// ----------------------------------------------------------------------
`define CLK_MHZ 40
`define TICK_US 100
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define US_TO_TICKS(us) ((us) / `TICK_US)
`define MS_TO_TICKS(ms) (((ms) * 1000) / `TICK_US)

// ----------------------------------------------------------------------
// deglitch period, ms
// ----------------------------------------------------------------------
`define DEGLITCH_MS 20
`define DEGLITCH_TICKS `MS_TO_TICKS(`DEGLITCH_MS)

// ----------------------------------------------------------------------
// setup delays, ms, per group: select low / floating / high
// ----------------------------------------------------------------------
`define SU_G0_LOW_MS 500
`define SU_G0_FLT_MS 1000
`define SU_G0_HIGH_MS 2000
`define SU_G1_LOW_MS 3000
`define SU_G1_FLT_MS 4000
`define SU_G1_HIGH_MS 5000
`define SU_G2_LOW_MS 6000
`define SU_G2_FLT_MS 8000
`define SU_G2_HIGH_MS 10000
`define SU_G3_LOW_MS 13000
`define SU_G3_FLT_MS 15000
`define SU_G3_HIGH_MS 17000
// seconds = kohm / 20, so ms per kohm is 1000 / 20
`define SU_RES_DIVISOR 20
`define SU_MS_PER_KOHM (1000 / `SU_RES_DIVISOR)

// ----------------------------------------------------------------------
// reset hold periods, us, index 0 to 12
// ----------------------------------------------------------------------
`define HOLD_0_US 900
`define HOLD_1_US 1800
`define HOLD_2_US 3600
`define HOLD_3_US 7200
`define HOLD_4_US 14400
`define HOLD_5_US 28800
`define HOLD_6_US 57600
`define HOLD_7_US 86400
`define HOLD_8_US 115200
`define HOLD_9_US 172800
`define HOLD_10_US 230400
`define HOLD_11_US 259200
`define HOLD_12_US 345600

`endif

/* File: verification/button_host_model.sv */
// partner model: pushbuttons with pull-ups and the host reset inputs
`timescale 1ns/100ps
`default_nettype none

module button_host_model (
  // clock
  input wire logic clk,
  // press requests from the bench
  input wire logic press_m,
  input wire logic press_a,
  input wire logic press_b,
  // button lines
  output logic manual_reset_in_n,
  output logic button_a_n,
  output logic button_b_n,
  // host reset inputs
  input wire logic host_rst_n,
  input wire logic dual_rst_n,
  // observed pulses
  output logic [7:0] pulses_single,
  output logic [7:0] pulses_dual,
  output logic [15:0] low_len
);
  logic [15:0] run_len;
  logic last_single;
  logic last_dual;

  // a released contact shows the pull-up level, never the last driven value
  assign manual_reset_in_n = press_m ? 1'b0 : 1'b1;
  assign button_a_n = press_a ? 1'b0 : 1'b1;
  assign button_b_n = press_b ? 1'b0 : 1'b1;

  initial begin
    pulses_single = 8'h00;
    pulses_dual = 8'h00;
    low_len = 16'h0000;
    run_len = 16'h0000;
    last_single = 1'b1;
    last_dual = 1'b1;
  end

  // ----------------------------------------------------------------------
  // host side: a pulse is counted when it ends, so a single-build pulse's length is known
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (host_rst_n === 1'b0) begin
      run_len <= run_len + 16'h0001;
    end
    if (host_rst_n === 1'b1 && last_single === 1'b0) begin
      pulses_single <= pulses_single + 8'h01;
      low_len <= run_len;
      run_len <= 16'h0000;
    end
    if (dual_rst_n === 1'b1 && last_dual === 1'b0) begin
      pulses_dual <= pulses_dual + 8'h01;
    end
    last_single <= host_rst_n;
    last_dual <= dual_rst_n;
  end
endmodule // button_host_model

`default_nettype wire

/* File: verification/pushbutton_reset_supervisor_tb.sv */
// testbench: single, dual and resistor builds side by side with one partner model
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_regs.svh"

module pushbutton_reset_supervisor_tb;
  localparam int TC = 2;
  localparam int DT = 3;
  localparam int SETUP_CYC = `MS_TO_TICKS(`SU_G0_LOW_MS) * TC;
  localparam int HOLD_CYC = `US_TO_TICKS(`HOLD_0_US) * TC;
  localparam int DEG_CYC = DT * TC;
  localparam int LO_CYC = SETUP_CYC + DEG_CYC - TC;
  localparam int HI_CYC = SETUP_CYC + DEG_CYC + 2 * TC + 6;
  localparam int LIMIT = 7 * SETUP_CYC + 10000;

  logic clk;
  logic rst_n;
  logic undervoltage;
  logic press_m;
  logic press_a;
  logic press_b;
  logic manual_reset_in_n;
  logic button_a_n;
  logic button_b_n;
  logic reset_out_n;
  logic soft_reset_out_n;
  logic dual_reset_n;
  logic res_reset_n;
  logic [1:0] sel;
  logic [9:0] kohm;
  logic [7:0] pulses_single;
  logic [7:0] pulses_dual;
  logic [15:0] low_len;
  logic [7:0] base_s;
  logic [7:0] base_d;
  int n_errors;
  int samples_checked;
  int cycles;
  int n;
  int m;

  // ----------------------------------------------------------------------
  // devices and partner
  // ----------------------------------------------------------------------
  pushbutton_reset_supervisor #(.TICK_CYCLES(TC), .DEGLITCH_TICKS(DT)) u_dut (
    .clk(clk), .rst_n(rst_n), .undervoltage(undervoltage),
    .manual_reset_in_n(manual_reset_in_n), .button_a_n(button_a_n), .button_b_n(button_b_n),
    .sel_level(sel), .sel_resistor_kohm(kohm),
    .reset_out_n(reset_out_n), .soft_reset_out_n(soft_reset_out_n));

  pushbutton_reset_supervisor #(.DUAL_BUTTON(1'b1), .TICK_CYCLES(TC), .DEGLITCH_TICKS(DT)) u_dual (
    .clk(clk), .rst_n(rst_n), .undervoltage(undervoltage),
    .manual_reset_in_n(manual_reset_in_n), .button_a_n(button_a_n), .button_b_n(button_b_n),
    .sel_level(sel), .sel_resistor_kohm(kohm),
    .reset_out_n(dual_reset_n), .soft_reset_out_n());

  // resistor build with the startup hold skipped
  pushbutton_reset_supervisor #(.RESISTOR_MODE(1'b1), .SKIP_STARTUP_HOLD(1'b1),
    .TICK_CYCLES(TC), .DEGLITCH_TICKS(DT)) u_res (
    .clk(clk), .rst_n(rst_n), .undervoltage(undervoltage),
    .manual_reset_in_n(manual_reset_in_n), .button_a_n(button_a_n), .button_b_n(button_b_n),
    .sel_level(sel), .sel_resistor_kohm(kohm),
    .reset_out_n(res_reset_n), .soft_reset_out_n());

  button_host_model u_partner (
    .clk(clk), .press_m(press_m), .press_a(press_a), .press_b(press_b),
    .manual_reset_in_n(manual_reset_in_n), .button_a_n(button_a_n), .button_b_n(button_b_n),
    .host_rst_n(reset_out_n), .dual_rst_n(dual_reset_n),
    .pulses_single(pulses_single), .pulses_dual(pulses_dual), .low_len(low_len));

  // ----------------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic summarize();
    $display("errors %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors = n_errors + 1;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
    end
  endtask

  // cycle counts come from the bench, so a window test on them is safe
  task automatic check_win(input int v, input int lo, input int hi);
    check({31'h0, (v >= lo && v <= hi)}, 32'h1);
  endtask

  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask

  // which: 0 single reset, 1 soft reset, 2 resistor build reset
  task automatic wait_out(input int which, input logic lvl, input int bound, output int cnt);
    cnt = 0;
    while ((which == 2 ? res_reset_n : which == 1 ? soft_reset_out_n : reset_out_n) !== lvl
        && cnt < bound) begin
      @(negedge clk);
      cnt = cnt + 1;
    end
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    undervoltage = 1'b0;
    press_m = 1'b0;
    press_a = 1'b0;
    press_b = 1'b0;
    sel = supervisor_pkg::SEL_LOW;
    kohm = 10'h00a;
    n_errors = 0;
    samples_checked = 0;
    cycles = 0;
    step(4);
    rst_n = 1'b1;
    // startup is held through the hold period
    step(HOLD_CYC - 8);
    check(reset_out_n, 1'b0);
    check(soft_reset_out_n, 1'b1);
    check(res_reset_n, 1'b1);
    wait_out(0, 1'b1, 40, n);
    check(reset_out_n, 1'b1);
    // brownout, then a full hold after the flag clears
    undervoltage = 1'b1;
    wait_out(0, 1'b0, 10, n);
    check_win(n, 3, 7);
    step(30);
    check(reset_out_n, 1'b0);
    check(res_reset_n, 1'b0);
    undervoltage = 1'b0;
    // the skip applies to startup only: a brownout still gets the full hold
    step(HOLD_CYC / 2);
    check(res_reset_n, 1'b0);
    wait_out(0, 1'b1, 80, n);
    check_win(n + HOLD_CYC / 2, HOLD_CYC - 2, HOLD_CYC + 10);
    check(res_reset_n, 1'b1);
    step(4);
    base_s = pulses_single;
    base_d = pulses_dual;
    // early release restarts the setup count; only one dual button held
    press_m = 1'b1;
    press_a = 1'b1;
    wait_out(1, 1'b0, 40, n);
    check_win(n, DEG_CYC - TC + 2, DEG_CYC + 6);
    step(SETUP_CYC / 2);
    press_m = 1'b0;
    wait_out(1, 1'b1, 8, n);
    check_win(n, 1, 6);
    step(20);
    press_m = 1'b1;
    step(SETUP_CYC * 3 / 4);
    check(pulses_single, base_s);
    wait_out(0, 1'b0, SETUP_CYC, n);
    check_win(n + SETUP_CYC * 3 / 4, LO_CYC, HI_CYC);
    check(res_reset_n, 1'b0);
    wait_out(0, 1'b1, HOLD_CYC + 3 * TC, n);
    step(2);
    check(pulses_single, base_s + 8'h01);
    check_win(low_len, HOLD_CYC - TC, HOLD_CYC + TC + 2);
    check(pulses_dual, base_d);
    // held on: no second pulse until a release
    step(SETUP_CYC + 200);
    check(pulses_single, base_s + 8'h01);
    press_m = 1'b0;
    press_a = 1'b0;
    step(20);
    press_m = 1'b1;
    press_a = 1'b1;
    press_b = 1'b1;
    wait_out(0, 1'b0, SETUP_CYC + 200, n);
    step(HOLD_CYC + 3 * TC);
    check(pulses_single, base_s + 8'h02);
    check(pulses_dual, base_d + 8'h01);
    press_m = 1'b0;
    press_a = 1'b0;
    press_b = 1'b0;
    // select floating gives one second; 15 kohm gives three quarters of a second
    sel = supervisor_pkg::SEL_FLOAT;
    kohm = 10'h00f;
    step(20);
    press_m = 1'b1;
    wait_out(2, 1'b0, 2 * SETUP_CYC, n);
    check_win(n, LO_CYC + SETUP_CYC / 2, HI_CYC + SETUP_CYC / 2);
    check(reset_out_n, 1'b1);
    m = n;
    wait_out(0, 1'b0, SETUP_CYC, n);
    check_win(m + n, LO_CYC + SETUP_CYC, HI_CYC + SETUP_CYC);
    press_m = 1'b0;
    summarize();
  end
endmodule // pushbutton_reset_supervisor_tb

`default_nettype wire
